// ==== hw/vsp_map.svh ====
`ifndef VSP_MAP_SVH
`define VSP_MAP_SVH

// Processor bus window, compared against address bits 31:20
`define VSP_WIN_BASE      12'h034
`define VSP_WIN_LSB       20

// Register numbers
`define VSP_NUM_ENTRY     8'h00
`define VSP_NUM_PTR       8'h01
`define VSP_NUM_BORDER    8'h04
`define VSP_NUM_CUR1      8'h05
`define VSP_NUM_CUR2      8'h06
`define VSP_NUM_CUR3      8'h07
`define VSP_NUM_EXT       8'h0c
`define VSP_NUM_FSYN      8'h0d
`define VSP_NUM_CTRL      8'h0e
`define VSP_NUM_FETCH     8'h0f
`define VSP_NUM_POFF0     8'h30
`define VSP_NUM_POFF1     8'h31
`define VSP_NUM_LPERIOD   8'h80
`define VSP_NUM_LSYNC     8'h81
`define VSP_NUM_LEDGE_B   8'h82
`define VSP_NUM_LPIC_B    8'h83
`define VSP_NUM_LPIC_F    8'h84
`define VSP_NUM_LEDGE_F   8'h85
`define VSP_NUM_LPTR_B    8'h86
`define VSP_NUM_LILACE    8'h87
`define VSP_NUM_LTEST_A   8'h88
`define VSP_NUM_FPERIOD   8'h90
`define VSP_NUM_FSYNC     8'h91
`define VSP_NUM_FEDGE_B   8'h92
`define VSP_NUM_FPIC_B    8'h93
`define VSP_NUM_FPIC_F    8'h94
`define VSP_NUM_FEDGE_F   8'h95
`define VSP_NUM_FPTR_B    8'h96
`define VSP_NUM_FPTR_F    8'h97
`define VSP_NUM_FTEST_A   8'h98
`define VSP_NUM_FTEST_B   8'h9a
`define VSP_NUM_FTEST_C   8'h9c
`define VSP_NUM_SND_RATE  8'hb0
`define VSP_NUM_SND_CTRL  8'hb1

// Top nibbles whose register number spans the full top byte
`define VSP_WIDE_NIB_MASK 16'h0f08

// Sizes
`define VSP_REG_COUNT     288
`define VSP_PAL_ENTRIES   256
`define VSP_CUR_WIDTH     32
`define VSP_CLK_SOURCES   3
`define VSP_DIV_MAX       8
`define VSP_SND_BITS      32
`define VSP_SND_CHAN_BITS 16

// Colour word fields
`define VSP_RED_LSB       0
`define VSP_GREEN_LSB     8
`define VSP_BLUE_LSB      16
`define VSP_EXTD_LSB      24

// General control fields
`define VSP_CTRL_PD_BIT   0
`define VSP_CTRL_MODE_LSB 1
`define VSP_CTRL_DEP_LSB  3
`define VSP_CTRL_SRC_LSB  6
`define VSP_CTRL_DIV_LSB  8
`define VSP_CTRL_DUAL_BIT 11

// Audio fields and control register reset value
`define VSP_SND_EN_BIT    0
`define VSP_CTRL_RESET    32'h0000_0000

`endif

// ==== hw/vsp_pkg.sv ====
package vsp_pkg;

    typedef enum logic [1:0] {
        VSP_MODE_NORMAL = 2'b00,
        VSP_MODE_HIRES  = 2'b01,
        VSP_MODE_LCD    = 2'b11
    } vsp_mode_e;

    typedef enum logic {
        VSP_SND_IDLE = 1'b0,
        VSP_SND_RUN  = 1'b1
    } vsp_snd_state_e;

    typedef struct packed {
        logic        en;
        logic [31:0] addr;
        logic [31:0] data;
    } vsp_bus_wr_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] index;
        logic [1:0] cursor;
        logic       border;
    } vsp_pix_in_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic [3:0] grey;
    } vsp_pix_out_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  num;
        logic [31:0] value;
    } vsp_cfg_wr_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] left;
        logic [15:0] right;
    } vsp_snd_in_s;

    typedef struct packed {
        logic bclk;
        logic lrck;
        logic data;
    } vsp_snd_pins_s;

endpackage : vsp_pkg

// ==== hw/vsp_regport.sv ====
`timescale 1ns/1ns
`include "vsp_map.svh"

module vsp_regport
    import vsp_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire vsp_bus_wr_s   bus_wr,
    input  wire vsp_pix_in_s   pix_in,
    input  wire logic [2:0]    pclk_src,
    input  wire vsp_snd_in_s   snd_in,
    output vsp_pix_out_s       pix_out_ff,
    output logic [3:0]         ext_port_ff,
    output logic [7:0]         seg_en_ff,
    output logic               dac_en_ff,
    output logic               grey_en_ff,
    output logic               panel_dual_ff,
    output logic               pix_tick_ff,
    output vsp_cfg_wr_s        cfg_wr_ff,
    output logic               snd_req_ff,
    output vsp_snd_pins_s      snd_pins_ff
);

    // Write decode
    logic [3:0]  wr_nib;
    logic [15:0] wide_mask;
    logic        wr_wide;
    logic        wr_hit;
    logic [7:0]  wr_num;
    logic        entry_wr;
    logic        ptr_wr;

    assign wr_nib   = bus_wr.data[31:28];
    assign wide_mask = `VSP_WIDE_NIB_MASK;
    assign wr_wide  = wide_mask[wr_nib];
    assign wr_hit   = bus_wr.en && (bus_wr.addr[31:`VSP_WIN_LSB] == `VSP_WIN_BASE);
    assign wr_num   = wr_wide ? bus_wr.data[31:24] : {4'h0, wr_nib};
    assign entry_wr = wr_hit && (wr_num == `VSP_NUM_ENTRY);
    assign ptr_wr   = wr_hit && (wr_num == `VSP_NUM_PTR);

    // Lookup memory and pointer; no read path exists toward the bus
    logic [27:0] pal_mem [`VSP_PAL_ENTRIES];
    logic [7:0]  ptr_ff;
    logic [7:0]  nxt_ptr;

    assign nxt_ptr = ptr_wr   ? bus_wr.data[7:0] :
                     entry_wr ? ptr_ff + 8'h01   :
                     ptr_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_ff <= 8'h00;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    // Memory has no reset so it maps onto a plain array
    always_ff @(posedge core_clk) begin
        if (entry_wr) begin
            pal_mem[ptr_ff] <= bus_wr.data[27:0];
        end
    end

    // Directly written registers kept inside the block
    logic [27:0] border_ff;
    logic [27:0] cur_col_ff [1:3];
    logic [31:0] ctrl_ff;
    logic [31:0] snd_rate_ff;
    logic [31:0] snd_ctrl_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            border_ff   <= 28'h0000000;
            ctrl_ff     <= `VSP_CTRL_RESET;
            snd_rate_ff <= 32'h0000_0000;
            snd_ctrl_ff <= 32'h0000_0000;
        end else if (wr_hit) begin
            case (wr_num)
                `VSP_NUM_BORDER:   border_ff   <= bus_wr.data[27:0];
                `VSP_NUM_CTRL:     ctrl_ff     <= bus_wr.data;
                `VSP_NUM_SND_RATE: snd_rate_ff <= bus_wr.data;
                `VSP_NUM_SND_CTRL: snd_ctrl_ff <= bus_wr.data;
                default:           border_ff   <= border_ff;
            endcase
        end
    end

    // Three overlay colours; code 00 has no storage of its own
    for (genvar c = 1; c <= 3; c++) begin : g_cur
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cur_col_ff[c] <= 28'h0000000;
            end else if (wr_hit && (wr_num == `VSP_NUM_BORDER + 8'(c))) begin
                cur_col_ff[c] <= bus_wr.data[27:0];
            end
        end
    end

    // Timing, panel offset, synth, fetch and external registers live downstream
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_wr_ff <= '0;
        end else begin
            cfg_wr_ff.valid <= wr_hit && !entry_wr && !ptr_wr;
            cfg_wr_ff.num   <= wr_num;
            cfg_wr_ff.value <= bus_wr.data;
        end
    end

    // Control fields
    logic       pd;
    vsp_mode_e  mode;
    logic [2:0] depth;
    logic [1:0] src_sel;
    logic [2:0] div_sel;
    logic       is_lcd;

    assign pd      = ctrl_ff[`VSP_CTRL_PD_BIT];
    assign mode    = vsp_mode_e'(ctrl_ff[`VSP_CTRL_MODE_LSB +: 2]);
    assign depth   = ctrl_ff[`VSP_CTRL_DEP_LSB +: 3];
    assign src_sel = ctrl_ff[`VSP_CTRL_SRC_LSB +: 2];
    assign div_sel = ctrl_ff[`VSP_CTRL_DIV_LSB +: 3];
    assign is_lcd  = (mode == VSP_MODE_LCD);

    // Pixel index width per depth; panels clamp above 4 bits
    logic [7:0]  idx_mask;
    logic [7:0]  pix_idx;
    logic [27:0] pal_q;
    logic [27:0] colour;
    logic [3:0]  grey_lvl;

    assign idx_mask = (depth == 3'd0) ? 8'h01 :
                      (depth == 3'd1) ? 8'h03 :
                      (depth == 3'd2 || is_lcd) ? 8'h0f : 8'hff;
    assign pix_idx  = pix_in.index & idx_mask;
    assign pal_q    = pal_mem[pix_idx];
    assign colour   = pix_in.border           ? border_ff :
                      (pix_in.cursor != 2'b00) ? cur_col_ff[pix_in.cursor] :
                      pal_q;
    assign grey_lvl = (depth == 3'd0) ? {4{pix_idx[0]}} :
                      (depth == 3'd1) ? {2{pix_idx[1:0]}} : pix_idx[3:0];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_out_ff  <= '0;
            ext_port_ff <= 4'h0;
        end else if (pd) begin
            pix_out_ff  <= '0;
            ext_port_ff <= 4'h0;
        end else if (pix_in.valid) begin
            pix_out_ff.valid <= 1'b1;
            pix_out_ff.red   <= colour[`VSP_RED_LSB +: 8];
            pix_out_ff.green <= colour[`VSP_GREEN_LSB +: 8];
            pix_out_ff.blue  <= colour[`VSP_BLUE_LSB +: 8];
            pix_out_ff.grey  <= is_lcd ? grey_lvl : 4'h0;
            ext_port_ff      <= colour[`VSP_EXTD_LSB +: 4];
        end else begin
            pix_out_ff.valid <= 1'b0;
        end
    end

    // Segment enable; a lookup takes the slot over a host write in the same cycle
    logic [7:0] nxt_seg;

    assign nxt_seg = (pix_in.valid && !pd) ? 8'h01 << pix_idx[7:5] :
                     entry_wr              ? 8'h01 << ptr_ff[7:5]  : 8'h00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_en_ff     <= 8'h00;
            dac_en_ff     <= 1'b0;
            grey_en_ff    <= 1'b0;
            panel_dual_ff <= 1'b0;
        end else begin
            seg_en_ff     <= nxt_seg;
            dac_en_ff     <= !pd && !is_lcd;
            grey_en_ff    <= !pd && is_lcd;
            panel_dual_ff <= is_lcd && ctrl_ff[`VSP_CTRL_DUAL_BIT];
        end
    end

    // Pixel clock sources arrive from pins: three flops, accept when last two agree
    logic [2:0] src_s1_ff;
    logic [2:0] src_s2_ff;
    logic [2:0] src_s3_ff;
    logic [2:0] src_lvl_ff;

    for (genvar s = 0; s < `VSP_CLK_SOURCES; s++) begin : g_sync
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                src_s1_ff[s]  <= 1'b0;
                src_s2_ff[s]  <= 1'b0;
                src_s3_ff[s]  <= 1'b0;
                src_lvl_ff[s] <= 1'b0;
            end else begin
                src_s1_ff[s] <= pclk_src[s];
                src_s2_ff[s] <= src_s1_ff[s];
                src_s3_ff[s] <= src_s2_ff[s];
                if (src_s2_ff[s] == src_s3_ff[s]) begin
                    src_lvl_ff[s] <= src_s3_ff[s];
                end
            end
        end
    end

    // Source code 3 falls back to source 0
    logic [1:0] src_idx;
    logic       src_rise;
    logic [2:0] div_cnt_ff;

    assign src_idx  = (src_sel == 2'd3) ? 2'd0 : src_sel;
    assign src_rise = (src_s2_ff[src_idx] == src_s3_ff[src_idx]) &&
                      src_s3_ff[src_idx] && !src_lvl_ff[src_idx];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_ff  <= 3'd0;
            pix_tick_ff <= 1'b0;
        end else begin
            pix_tick_ff <= 1'b0;
            if (pd) begin
                div_cnt_ff <= 3'd0;
            end else if (src_rise) begin
                if (div_cnt_ff >= div_sel) begin
                    div_cnt_ff  <= 3'd0;
                    pix_tick_ff <= 1'b1;
                end else begin
                    div_cnt_ff <= div_cnt_ff + 3'd1;
                end
            end
        end
    end

    // Audio: rate counter sets half bit-clock period of rate+1 core cycles
    vsp_snd_state_e snd_st_ff;
    logic [7:0]     snd_div_ff;
    logic           snd_half;
    logic           snd_step;
    logic [4:0]     snd_cnt_ff;
    logic [31:0]    snd_sh_ff;
    logic [31:0]    snd_next_ff;
    logic           snd_full_ff;
    logic           snd_en;
    logic           snd_take;
    logic [31:0]    snd_load;

    assign snd_en   = snd_ctrl_ff[`VSP_SND_EN_BIT] && !pd;
    assign snd_half = (snd_st_ff == VSP_SND_RUN) && (snd_div_ff == snd_rate_ff[7:0]);
    assign snd_step = snd_half && snd_pins_ff.bclk;
    assign snd_take = snd_req_ff && snd_in.valid;
    assign snd_load = snd_full_ff ? snd_next_ff : 32'h0000_0000;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            snd_st_ff <= VSP_SND_IDLE;
            snd_div_ff <= 8'h00;
        end else begin
            case (snd_st_ff)
                VSP_SND_IDLE: snd_st_ff <= snd_en ? VSP_SND_RUN : VSP_SND_IDLE;
                VSP_SND_RUN:  snd_st_ff <= snd_en ? VSP_SND_RUN : VSP_SND_IDLE;
                default:      snd_st_ff <= VSP_SND_IDLE;
            endcase
            snd_div_ff <= snd_half || (snd_st_ff != VSP_SND_RUN) ? 8'h00 : snd_div_ff + 8'h01;
        end
    end

    // One sample of look-ahead; an empty slot at frame end sends silence
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            snd_req_ff  <= 1'b0;
            snd_full_ff <= 1'b0;
            snd_next_ff <= 32'h0000_0000;
        end else begin
            snd_req_ff <= snd_en && !snd_full_ff && !snd_take;
            if (snd_take) begin
                snd_next_ff <= {snd_in.left, snd_in.right};
                snd_full_ff <= 1'b1;
            end else if (snd_step && (snd_cnt_ff == 5'd31)) begin
                snd_full_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            snd_cnt_ff  <= 5'd31;
            snd_sh_ff   <= 32'h0000_0000;
            snd_pins_ff <= '0;
        end else if (snd_st_ff != VSP_SND_RUN) begin
            snd_cnt_ff  <= 5'd31;
            snd_pins_ff <= '0;
        end else begin
            if (snd_half) begin
                snd_pins_ff.bclk <= !snd_pins_ff.bclk;
            end
            if (snd_step) begin
                snd_cnt_ff       <= snd_cnt_ff + 5'd1;
                snd_pins_ff.lrck <= (snd_cnt_ff + 5'd1) >= 5'(`VSP_SND_CHAN_BITS);
                if (snd_cnt_ff == 5'd31) begin
                    snd_pins_ff.data <= snd_load[31];
                    snd_sh_ff        <= {snd_load[30:0], 1'b0};
                end else begin
                    snd_pins_ff.data <= snd_sh_ff[31];
                    snd_sh_ff        <= {snd_sh_ff[30:0], 1'b0};
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence entry_write_s;
        entry_wr && !ptr_wr;
    endsequence

    sequence snd_mid_step_s;
        snd_step && (snd_cnt_ff == 5'd15);
    endsequence

    ptr_advance_a: assert property (entry_write_s |=> ptr_ff == $past(ptr_ff) + 8'h01)
        else $error("pointer did not advance after entry write");

    ptr_load_a: assert property (ptr_wr |=> ptr_ff == $past(bus_wr.data[7:0]))
        else $error("pointer not loaded from register 1 write");

    direct_keeps_ptr_a: assert property (wr_hit && !entry_wr && !ptr_wr |=> $stable(ptr_ff))
        else $error("direct register write moved the pointer");

    window_guard_a: assert property (bus_wr.en && bus_wr.addr[31:20] != 12'h034
                                     |=> $stable(ctrl_ff) && $stable(ptr_ff) && !cfg_wr_ff.valid)
        else $error("write outside window changed state");

    overlay_colour_a: assert property (pix_in.valid && !pd && !pix_in.border && pix_in.cursor == 2'b10
                                       |=> pix_out_ff.red == $past(cur_col_ff[2][7:0]))
        else $error("overlay colour 2 not shown");

    segment_onehot_a: assert property ($onehot0(seg_en_ff))
        else $error("more than one lookup segment enabled");

    power_down_a: assert property (pd ##1 pd |-> !dac_en_ff && !grey_en_ff && !pix_out_ff.valid)
        else $error("converters or pixels active in power down");

    divider_range_a: assert property (pix_tick_ff |-> div_cnt_ff == 3'd0 && !$past(pd))
        else $error("pixel tick without divider wrap");

    channel_swap_a: assert property (snd_mid_step_s |=> snd_pins_ff.lrck && snd_cnt_ff == 5'd16)
        else $error("right channel did not start at bit 16");

    frame_start_a: assert property (snd_step && snd_cnt_ff == 5'd31 |=> !snd_pins_ff.lrck)
        else $error("left channel did not start at frame start");

endmodule : vsp_regport

// ==== sim/video_sound_register_port_bench.sv ====
`timescale 1ns/1ns
`include "vsp_map.svh"
module video_sound_register_port_bench;
    import vsp_pkg::*;
    typedef struct packed {logic [27:0] col; logic [7:0] seg;} vsp_exp_s;
    logic          core_clk;
    logic          rst_n;
    vsp_bus_wr_s   bus_wr;
    vsp_pix_in_s   pix_in;
    logic [2:0]    pclk_src;
    vsp_snd_in_s   snd_in;
    vsp_pix_out_s  pix_out_ff;
    logic [3:0]    ext_port_ff;
    logic [7:0]    seg_en_ff;
    logic          dac_en_ff;
    logic          grey_en_ff;
    logic          panel_dual_ff;
    vsp_cfg_wr_s   cfg_wr_ff;
    logic          snd_req_ff;
    logic          pix_tick_ff;
    vsp_snd_pins_s snd_pins_ff;
    int            error_cnt;
    int            total_checks;
    int            seed;
    vsp_exp_s      pix_q[$];
    logic [39:0]   cfg_q[$];
    vsp_exp_s      mon_e;
    logic [39:0]   mon_c;
    logic [27:0]   col[0:3];
    logic [27:0]   ovl[1:3];
    logic [31:0]   win;
    logic [31:0]   smp;
    int            ticks;
    int            t0;

    vsp_regport u_vsp_regport (.core_clk(core_clk), .rst_n(rst_n), .bus_wr(bus_wr), .pix_in(pix_in),
        .pclk_src(pclk_src), .snd_in(snd_in), .pix_out_ff(pix_out_ff), .ext_port_ff(ext_port_ff),
        .seg_en_ff(seg_en_ff), .dac_en_ff(dac_en_ff), .grey_en_ff(grey_en_ff), .panel_dual_ff(panel_dual_ff),
        .pix_tick_ff(pix_tick_ff), .cfg_wr_ff(cfg_wr_ff), .snd_req_ff(snd_req_ff), .snd_pins_ff(snd_pins_ff));
    vsp_host_model u_vsp_host_model (.core_clk(core_clk), .bus_wr(bus_wr));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    // Register number rides in the top nibble, or the top byte for wide nibbles
    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [7:0] num;
        num = (data[31:28] inside {4'h3, 4'h8, 4'h9, 4'ha, 4'hb}) ? data[31:24] : {4'h0, data[31:28]};
        if (addr[31:20] == 12'h034 && num > 8'h01) cfg_q.push_back({num, data});
        u_vsp_host_model.write(addr, data);
    endtask : wr

    // Holds valid so calls in a row give back-to-back pixels
    task automatic pix(input logic [7:0] idx, input logic [1:0] cur, input logic brd,
                       input logic [27:0] c, input logic [7:0] seg, input logic take);
        @(posedge core_clk);
        #1;
        pix_in = '{valid: 1'b1, index: idx, cursor: cur, border: brd};
        if (take) pix_q.push_back('{col: c, seg: seg});
    endtask : pix

    task automatic idle(input int n);
        @(posedge core_clk);
        #1;
        pix_in.valid = 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask : idle

    always @(negedge core_clk) begin
        if (rst_n && pix_out_ff.valid === 1'b1) begin
            if (pix_q.size() == 0) chk("stray pixel", 40'h0, 40'h1);
            else begin
                mon_e = pix_q.pop_front();
                chk("pixel colour", 40'(mon_e.col),
                    40'({ext_port_ff, pix_out_ff.blue, pix_out_ff.green, pix_out_ff.red}));
                if (mon_e.seg != 8'h00) chk("segment", 40'(mon_e.seg), 40'(seg_en_ff));
            end
        end
        if (rst_n && cfg_wr_ff.valid === 1'b1) begin
            mon_c = (cfg_q.size() == 0) ? 40'h0 : cfg_q.pop_front();
            chk("config write", mon_c, {cfg_wr_ff.num, cfg_wr_ff.value});
        end
    end

    always @(posedge core_clk) #1 pclk_src = 3'($random(seed));

    always @(negedge core_clk) if (pix_tick_ff === 1'b1) ticks++;

    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        seed = 10;
        rst_n = 1'b0;
        pix_in = '0;
        snd_in = '0;
        win = 32'h0340_0000;
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        @(negedge core_clk);
        chk("reset outputs", 40'h0, {pix_out_ff.valid, cfg_wr_ff.valid, seg_en_ff, snd_req_ff});
        for (int i = 0; i < 4; i++) col[i] = 28'($random(seed));
        wr(win, 32'he000_0018);
        wr(32'h034f_ffff, 32'h1000_00fe);
        wr({12'h034, 20'($random(seed))}, {4'h0, col[0]});
        wr(win, {4'h4, col[3]});
        wr(32'h0350_0000, 32'h1000_0010);
        wr(32'h033f_ffff, 32'hc000_0001);
        wr(win, {4'h0, col[1]});
        wr(win, {4'h0, col[2]});
        wr(win, 32'h8000_1230);
        wr(win, 32'hc000_0005);
        pix(8'hfe, 2'b00, 1'b0, col[0], 8'h80, 1'b1);
        pix(8'hff, 2'b00, 1'b0, col[1], 8'h80, 1'b1);
        pix(8'h00, 2'b00, 1'b0, col[2], 8'h01, 1'b1);
        idle(2);
        chk("converters on", 40'h1, 40'(dac_en_ff));
        $display("test lookup done");
        for (int n = 1; n < 4; n++) begin
            ovl[n] = 28'($random(seed));
            wr(win, {4'(4 + n), ovl[n]});
        end
        for (int m = 0; m < 3; m++) begin
            wr(win, 32'he000_0018 | (32'((m == 2) ? 3 : m) << 1));
            for (int n = 1; n < 4; n++) pix(8'h00, 2'(n), 1'b0, ovl[n], 8'h00, 1'b1);
            pix(8'h00, 2'b00, 1'b0, col[2], 8'h01, 1'b1);
            pix(8'hff, 2'b10, 1'b1, col[3], 8'h00, 1'b1);
            idle(2);
        end
        $display("test overlay done");
        wr(win, 32'he000_0806);
        idle(2);
        chk("panel flags", 40'h5, {grey_en_ff, dac_en_ff, panel_dual_ff});
        pix(8'h01, 2'b00, 1'b1, col[3], 8'h00, 1'b1);
        idle(0);
        @(negedge core_clk);
        chk("grey level", 40'hf, 40'(pix_out_ff.grey));
        wr(win, 32'he000_0019);
        pix(8'h00, 2'b00, 1'b0, col[2], 8'h00, 1'b0);
        idle(2);
        chk("power down flags", 40'h0, {grey_en_ff, dac_en_ff});
        t0 = ticks;
        repeat (20) @(posedge core_clk);
        chk("ticks in power down", 40'h0, 40'(ticks - t0));
        $display("test power done");
        // Audio is held off while power down stands
        wr(win, 32'he000_0018);
        t0 = ticks;
        wr(win, 32'hb000_0003);
        wr(win, 32'hb100_0001);
        for (int k = 0; k < 20 && snd_req_ff !== 1'b1; k++) @(negedge core_clk);
        chk("sample wanted", 40'h1, 40'(snd_req_ff));
        smp = {16'($random(seed)), 16'($random(seed))};
        @(posedge core_clk);
        #1;
        snd_in = '{valid: 1'b1, left: smp[31:16], right: smp[15:0]};
        @(posedge core_clk);
        #1;
        snd_in.valid = 1'b0;
        // First falling bit clock opens the frame that carries the sample
        @(negedge snd_pins_ff.bclk);
        for (int b = 0; b < 32; b++) begin
            @(posedge snd_pins_ff.bclk);
            chk("audio bit", 40'({b >= 16, smp[31 - b]}), 40'({snd_pins_ff.lrck, snd_pins_ff.data}));
        end
        chk("ticks running", 40'h1, 40'(ticks > t0));
        $display("test audio done");
        idle(4);
        chk("queues drained", 40'h0, 40'(pix_q.size() + cfg_q.size()));
        wrap_up();
    end
endmodule : video_sound_register_port_bench

// ==== sim/vsp_host_model.sv ====
`timescale 1ns/1ns
module vsp_host_model
    import vsp_pkg::*;
(
    input  wire logic  core_clk,
    output vsp_bus_wr_s bus_wr
);
    initial bus_wr = '0;

    // One write per call; the bus is released between calls
    task automatic write(input logic [31:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        #1;
        bus_wr = '{en: 1'b1, addr: addr, data: data};
        @(posedge core_clk);
        #1;
        // Inverted word so a stale value cannot pass for a live one
        bus_wr = '{en: 1'b0, addr: ~addr, data: ~data};
    endtask : write
endmodule : vsp_host_model
